// ==== cgmos_consts.vh ====
// constants for the clock generator mode, select and output suspend registers
`ifndef CGMOS_CONSTS_VH
`define CGMOS_CONSTS_VH

// register offsets
`define CGMOS_ADDR_SRC      8'h00
`define CGMOS_ADDR_IDX      8'h01
`define CGMOS_ADDR_PSE      8'h02
`define CGMOS_ADDR_FSN      8'h03

// reset values
`define CGMOS_RST_SRC       8'h00
`define CGMOS_RST_IDX       8'h00
`define CGMOS_RST_PSE       8'h02
`define CGMOS_RST_FSN       8'h02

// implemented bits, reserved bits read as zero
`define CGMOS_MASK_SRC      8'h01
`define CGMOS_MASK_IDX      8'h07
`define CGMOS_MASK_PSE      8'hCF
`define CGMOS_MASK_FSN      8'h4F
`define CGMOS_MASK_OUT      7'h4F

// field positions
`define CGMOS_SRC_BIT       0
`define CGMOS_IDX_MSB       2
`define CGMOS_OUT_MSB       6

// serial interface
`define CGMOS_DEV_ADDR      7'h6A
`define CGMOS_BITS_BYTE     4'h8
`define CGMOS_SYNC_RST      6'h03

// lock timing
`define CGMOS_CLK_KHZ       100000
`define CGMOS_LOCK_PU_MS    10
`define CGMOS_LOCK_SD_MS    1

`endif

// ==== cgmos_regs.v ====
// clock generator mode, configuration select and output suspend registers behind a two-wire serial slave
`timescale 1ns/10ps
`default_nettype none
`include "cgmos_consts.vh"

module cgmos_regs #(
	parameter [6:0] DEV_ADDR    = `CGMOS_DEV_ADDR,
	parameter       LOCK_PU_CYC = `CGMOS_LOCK_PU_MS * `CGMOS_CLK_KHZ,
	parameter       LOCK_SD_CYC = `CGMOS_LOCK_SD_MS * `CGMOS_CLK_KHZ,
	parameter       TMR_W       = 21
) (
	// clock and reset
	input  wire       clk_i,
	input  wire       arst_n_i,
	// serial bus pins
	input  wire       scl_i,
	input  wire       sda_i,
	output reg        sda_o,
	output reg        sda_oe_o,
	// device pins
	input  wire [2:0] sel_pins_i,
	input  wire       shutdown_outen_pin_i,
	// to the clock core
	output reg  [2:0] active_cfg_o,
	output reg  [6:0] out_enable_o,
	output reg        pll_lock_o
);

	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_ADDR = 4'h1;
	localparam [3:0] ST_AACK = 4'h2;
	localparam [3:0] ST_WR   = 4'h3;
	localparam [3:0] ST_WACK = 4'h4;
	localparam [3:0] ST_RD   = 4'h5;
	localparam [3:0] ST_RACK = 4'h6;
	localparam [3:0] ST_WAIT = 4'h7;

	localparam [TMR_W-1:0] PU_CYC = LOCK_PU_CYC[TMR_W-1:0];
	localparam [TMR_W-1:0] SD_CYC = LOCK_SD_CYC[TMR_W-1:0];

	// register read mux with reserved bits forced to zero
	function [7:0] rd_fn;
		input [7:0] a;
		input [7:0] src;
		input [7:0] idx;
		input [7:0] pse;
		input [7:0] fsn;
		begin
			case (a)
				`CGMOS_ADDR_SRC: rd_fn = src & `CGMOS_MASK_SRC;
				`CGMOS_ADDR_IDX: rd_fn = idx & `CGMOS_MASK_IDX;
				`CGMOS_ADDR_PSE: rd_fn = pse & `CGMOS_MASK_PSE;
				`CGMOS_ADDR_FSN: rd_fn = fsn & `CGMOS_MASK_FSN;
				default:         rd_fn = 8'h00;
			endcase
		end
	endfunction

	// three-stage pin synchronisers: {sel[2:0], shutdown, scl, sda}
	reg  [5:0] s1_reg;
	reg  [5:0] s2_reg;
	reg  [5:0] s3_reg;
	reg  [5:0] filt_reg;
	// take stage three when it agrees with stage two, otherwise hold the last agreed level
	wire [5:0] filt_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));

	// configuration registers
	reg [7:0] src_reg;
	reg [7:0] idx_reg;
	reg [7:0] pse_reg;
	reg [7:0] fsn_reg;

	// serial slave state
	reg [3:0] st_reg;
	reg [3:0] cnt_reg;
	reg [7:0] sh_reg;
	reg [7:0] ptr_reg;
	reg       have_ptr_reg;
	reg       nack_reg;

	// lock sequencing
	reg [TMR_W-1:0] tmr_reg;
	reg             sd_prev_reg;
	reg             loaded_reg;

	wire scl_f    = filt_reg[1];
	wire sda_f    = filt_reg[0];
	wire scl_n    = filt_next[1];
	wire sda_n    = filt_next[0];
	wire scl_rise = ~scl_f & scl_n;
	wire scl_fall = scl_f & ~scl_n;
	wire start_c  = scl_f & scl_n & sda_f & ~sda_n;
	wire stop_c   = scl_f & scl_n & ~sda_f & sda_n;
	wire sd_act   = filt_reg[2];
	wire [7:0] rd_data = rd_fn(ptr_reg, src_reg, idx_reg, pse_reg, fsn_reg);

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1_reg       <= `CGMOS_SYNC_RST;
			s2_reg       <= `CGMOS_SYNC_RST;
			s3_reg       <= `CGMOS_SYNC_RST;
			filt_reg     <= `CGMOS_SYNC_RST;
			src_reg      <= `CGMOS_RST_SRC;
			idx_reg      <= `CGMOS_RST_IDX;
			pse_reg      <= `CGMOS_RST_PSE;
			fsn_reg      <= `CGMOS_RST_FSN;
			st_reg       <= ST_IDLE;
			cnt_reg      <= 4'h0;
			sh_reg       <= 8'h00;
			ptr_reg      <= 8'h00;
			have_ptr_reg <= 1'b0;
			nack_reg     <= 1'b0;
			sda_o        <= 1'b0;
			sda_oe_o     <= 1'b0;
			tmr_reg      <= PU_CYC;
			sd_prev_reg  <= 1'b0;
			pll_lock_o   <= 1'b0;
			loaded_reg   <= 1'b0;
			active_cfg_o <= 3'h0;
			out_enable_o <= 7'h00;
		end else begin
			s1_reg      <= {sel_pins_i, shutdown_outen_pin_i, scl_i, sda_i};
			s2_reg      <= s1_reg;
			s3_reg      <= s2_reg;
			// a change is taken only once stages two and three agree
			filt_reg    <= filt_next;
			sda_o       <= 1'b0;
			sd_prev_reg <= sd_act;

			// bus slave; start and stop win over any bit activity
			if (start_c) begin
				st_reg   <= ST_ADDR;
				cnt_reg  <= 4'h0;
				sda_oe_o <= 1'b0;
			end else if (stop_c) begin
				st_reg   <= ST_IDLE;
				sda_oe_o <= 1'b0;
			end else begin
				case (st_reg)
					ST_ADDR, ST_WR: begin
						if (scl_rise) begin
							sh_reg  <= {sh_reg[6:0], sda_f};
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall && cnt_reg == `CGMOS_BITS_BYTE) begin
							cnt_reg <= 4'h0;
							if (st_reg == ST_ADDR) begin
								if (sh_reg[7:1] == DEV_ADDR) begin
									sda_oe_o     <= 1'b1;
									nack_reg     <= sh_reg[0];
									have_ptr_reg <= 1'b0;
									st_reg       <= ST_AACK;
								end else begin
									st_reg <= ST_WAIT;
								end
							end else begin
								sda_oe_o <= 1'b1;
								st_reg   <= ST_WACK;
								if (!have_ptr_reg) begin
									ptr_reg      <= sh_reg;
									have_ptr_reg <= 1'b1;
								end else begin
									// host may set reserved bits, masks make that harmless
									case (ptr_reg)
										`CGMOS_ADDR_SRC: src_reg <= sh_reg & `CGMOS_MASK_SRC;
										`CGMOS_ADDR_IDX: idx_reg <= sh_reg & `CGMOS_MASK_IDX;
										`CGMOS_ADDR_PSE: pse_reg <= sh_reg & `CGMOS_MASK_PSE;
										`CGMOS_ADDR_FSN: fsn_reg <= sh_reg & `CGMOS_MASK_FSN;
										default: ;
									endcase
									ptr_reg <= ptr_reg + 8'h01;
								end
							end
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							if (nack_reg) begin
								// read: nack_reg held the direction bit here
								sh_reg   <= rd_data;
								sda_oe_o <= ~rd_data[7];
								ptr_reg  <= ptr_reg + 8'h01;
								st_reg   <= ST_RD;
							end else begin
								sda_oe_o <= 1'b0;
								st_reg   <= ST_WR;
							end
						end
					end
					ST_WACK: begin
						if (scl_fall) begin
							sda_oe_o <= 1'b0;
							st_reg   <= ST_WR;
						end
					end
					ST_RD: begin
						if (scl_rise) begin
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall) begin
							if (cnt_reg == `CGMOS_BITS_BYTE) begin
								cnt_reg  <= 4'h0;
								sda_oe_o <= 1'b0;
								st_reg   <= ST_RACK;
							end else begin
								sh_reg   <= {sh_reg[6:0], 1'b0};
								sda_oe_o <= ~sh_reg[6];
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							nack_reg <= sda_f;
						end else if (scl_fall) begin
							if (nack_reg) begin
								st_reg <= ST_WAIT;
							end else begin
								sh_reg   <= rd_data;
								sda_oe_o <= ~rd_data[7];
								ptr_reg  <= ptr_reg + 8'h01;
								st_reg   <= ST_RD;
							end
						end
					end
					default: ;
				endcase
			end

			// lock timer: power-up load then relock after each shutdown exit
			if (sd_prev_reg && !sd_act) begin
				tmr_reg    <= SD_CYC;
				pll_lock_o <= 1'b0;
			end else if (sd_act) begin
				pll_lock_o <= 1'b0;
			end else if (tmr_reg != {TMR_W{1'b0}}) begin
				tmr_reg    <= tmr_reg - {{(TMR_W-1){1'b0}}, 1'b1};
			end else begin
				pll_lock_o <= 1'b1;
				loaded_reg <= 1'b1;
			end

			// configuration source: register field or synchronised select pins
			active_cfg_o <= src_reg[`CGMOS_SRC_BIT] ? idx_reg[`CGMOS_IDX_MSB:0] : filt_reg[5:3];

			// pin tie overrides the forced bit; all outputs stay off until the first load completes
			// untied outputs keep their enable through shutdown, so they do not follow the relock
			out_enable_o <= {7{loaded_reg}} & `CGMOS_MASK_OUT & fsn_reg[`CGMOS_OUT_MSB:0] &
			                ~(pse_reg[`CGMOS_OUT_MSB:0] & {7{sd_act}});
		end
	end

endmodule // cgmos_regs
`default_nettype wire

// ==== cgmos_consts_note_unused.v ====
`timescale 1ns/10ps

// ==== cgmos_regs_checker.sv ====
// assertions on the lock and output suspend ports
`timescale 1ns/10ps
`default_nettype none
module cgmos_regs_checker #(
	parameter LOCK_PU_CYC = 20,
	parameter LOCK_SD_CYC = 5
) (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       arst_n_i,
	// pins and outputs
	input wire logic       scl_i,
	input wire logic       shutdown_outen_pin_i,
	input wire logic [6:0] out_enable_o,
	input wire logic       pll_lock_o
);
	// slack covers the pin synchroniser and the register stage
	localparam int PU_MAX = LOCK_PU_CYC + 8;
	localparam int SD_MAX = LOCK_SD_CYC + 12;
	// a register write lands a few cycles after a serial clock fall
	localparam int WR_LAG = 10;
	// lock waits are counted, since the default timer spans a million cycles
	int   pu_cnt;
	int   sd_cnt;
	int   scl_lo_cnt;
	logic seen_lock;
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			seen_lock  <= 1'b0;
			pu_cnt     <= 0;
			sd_cnt     <= 0;
			scl_lo_cnt <= 0;
		end else begin
			if (pll_lock_o)
				seen_lock <= 1'b1;
			if (!seen_lock && !pll_lock_o && !shutdown_outen_pin_i)
				pu_cnt <= pu_cnt + 1;
			if (pll_lock_o || shutdown_outen_pin_i)
				sd_cnt <= 0;
			else if (seen_lock)
				sd_cnt <= sd_cnt + 1;
			if (scl_i)
				scl_lo_cnt <= 0;
			else if (scl_lo_cnt < WR_LAG)
				scl_lo_cnt <= scl_lo_cnt + 1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_sd_held;
		shutdown_outen_pin_i [*8];
	endsequence
	a_reserved_low: assert property (out_enable_o[5:4] == 2'b00)
		else $error("reserved output on");
	a_nolock_off: assert property (!seen_lock |-> out_enable_o == 7'h00)
		else $error("output on before first lock");
	a_pu_bound: assert property (pu_cnt <= PU_MAX)
		else $error("power-up lock late");
	a_rise_order: assert property ($rose(pll_lock_o) && !seen_lock |-> out_enable_o == 7'h00)
		else $error("output before lock");
	a_sd_drop: assert property (s_sd_held |-> !pll_lock_o)
		else $error("lock kept in shutdown");
	a_sd_no_rise: assert property (s_sd_held |-> ((out_enable_o & ~$past(out_enable_o)) == 7'h00) || (scl_lo_cnt < WR_LAG))
		else $error("output turned on in shutdown");
	a_relock_bound: assert property (sd_cnt <= SD_MAX)
		else $error("relock late");
	a_fall_cause: assert property ($fell(pll_lock_o) |-> shutdown_outen_pin_i)
		else $error("lock lost without shutdown");
endmodule // cgmos_regs_checker

bind cgmos_regs cgmos_regs_checker #(
	.LOCK_PU_CYC(LOCK_PU_CYC),
	.LOCK_SD_CYC(LOCK_SD_CYC)
) i_cgmos_regs_checker (
	.clk_i(clk_i),
	.arst_n_i(arst_n_i),
	.scl_i(scl_i),
	.shutdown_outen_pin_i(shutdown_outen_pin_i),
	.out_enable_o(out_enable_o),
	.pll_lock_o(pll_lock_o)
);
`default_nettype wire

// ==== cgmos_host_model.sv ====
// two-wire bus host model on a pulled-up open-drain data line
`timescale 1ns/10ps
`default_nettype none
module cgmos_host (
	input  wire logic clk_i,
	input  wire logic sda_oe_i,
	output var  logic scl_o,
	output wire logic sda_o
);
	logic pull = 1'b0;
	initial scl_o = 1'b1;
	// released line floats up to the pull-up level
	assign sda_o = ~(pull | sda_oe_i);
	task automatic hp;
		repeat (20) @(negedge clk_i);
	endtask
	// data moves well inside the low phase, never beside a clock edge
	task automatic mid;
		repeat (5) @(negedge clk_i);
	endtask
	task automatic start;
		mid;
		pull = 1'b0;
		hp;
		scl_o = 1'b1;
		hp;
		pull = 1'b1;
		hp;
		scl_o = 1'b0;
	endtask
	task automatic stop;
		mid;
		pull = 1'b1;
		hp;
		scl_o = 1'b1;
		hp;
		pull = 1'b0;
		hp;
	endtask
	task automatic bitx(input logic b, output logic r);
		mid;
		pull = ~b;
		hp;
		scl_o = 1'b1;
		hp;
		r = sda_o;
		scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ak);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(ai, ak);
	endtask
endmodule // cgmos_host
`default_nettype wire

// ==== tb.sv ====
// testbench for the mode, select and output suspend registers
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic       clk_i = 1'b0;
	logic       arst_n_i = 1'b0;
	logic [2:0] sel = 3'h5;
	logic       sd = 1'b0;
	wire        scl;
	wire        sda;
	wire        oe;
	wire        sdo;
	wire  [2:0] cfg;
	wire  [6:0] oen;
	wire        lock;
	int         errors = 0;
	int         total_checks = 0;
	initial forever #5 clk_i = ~clk_i;
	cgmos_regs #(.LOCK_PU_CYC(20), .LOCK_SD_CYC(5)) i_cgmos_regs (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .sel_pins_i(sel), .shutdown_outen_pin_i(sd),
		.active_cfg_o(cfg), .out_enable_o(oen), .pll_lock_o(lock));
	cgmos_host i_cgmos_host (.clk_i(clk_i), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       ak;
		i_cgmos_host.start;
		i_cgmos_host.xfer(8'hD4, 1'b1, q, ak);
		i_cgmos_host.xfer(a, 1'b1, q, ak);
		i_cgmos_host.xfer(d, 1'b1, q, ak);
		chk("ack", 8'h00, {7'h0, ak});
		i_cgmos_host.stop;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		logic [7:0] x;
		logic       ak;
		i_cgmos_host.start;
		i_cgmos_host.xfer(8'hD4, 1'b1, x, ak);
		i_cgmos_host.xfer(a, 1'b1, x, ak);
		i_cgmos_host.start;
		i_cgmos_host.xfer(8'hD5, 1'b1, x, ak);
		i_cgmos_host.xfer(8'hFF, 1'b1, q, ak);
		i_cgmos_host.stop;
	endtask
	task automatic t_reset;
		logic [7:0] rv [4] = '{8'h00, 8'h00, 8'h02, 8'h02};
		logic [7:0] q;
		for (int a = 0; a < 4; a++) begin
			rd(a[7:0], q);
			chk("reset value", rv[a], q);
		end
		chk("outs", 8'h02, {1'b0, oen});
		chk("sda drive", 8'h00, {7'h0, sdo});
	endtask
	task automatic t_mode;
		chk("pin cfg", 8'h05, {5'h0, cfg});
		wr(8'h01, 8'h03);
		wr(8'h00, 8'h01);
		chk("sw cfg", 8'h03, {5'h0, cfg});
		sel = 3'h6;
		repeat (10) @(negedge clk_i);
		chk("pins ignored", 8'h03, {5'h0, cfg});
		wr(8'h00, 8'h00);
		chk("pin cfg", 8'h06, {5'h0, cfg});
	endtask
	task automatic t_suspend;
		logic [7:0] q;
		wr(8'h03, 8'h4F);
		chk("outs", 8'h4F, {1'b0, oen});
		rd(8'h03, q);
		chk("fsn", 8'h4F, q);
		wr(8'h02, 8'h0F);
		sd = 1'b1;
		repeat (10) @(negedge clk_i);
		chk("sd outs", 8'h40, {1'b0, oen});
		sd = 1'b0;
		repeat (3) @(negedge clk_i);
		chk("lock", 8'h00, {7'h0, lock});
		repeat (15) @(negedge clk_i);
		chk("relock", 8'h01, {7'h0, lock});
		wr(8'h03, 8'h4A);
		chk("forced", 8'h4A, {1'b0, oen});
	endtask
	initial begin
		#600us;
		errors++;
		print_verdict;
	end
	initial begin
		repeat (10) @(negedge clk_i);
		arst_n_i = 1'b1;
		repeat (40) @(negedge clk_i);
		t_reset;
		t_mode;
		t_suspend;
		print_verdict;
	end
endmodule // tb
`default_nettype wire
